// [ofr_map.svh]
// register map, field layout, reset values of the rx fifo drop / overflow bank
// assumes word-wide registers reached at byte address = 4 * index
`ifndef OFR_MAP_SVH
`define OFR_MAP_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define OFR_PORTS 10
`define OFR_ADDR_W 16
`define OFR_DATA_W 32

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define OFR_IDX_DROP_EN 12'h59f
`define OFR_IDX_OVF_EVT 12'h5a0
`define OFR_IDX_IRQ_STAT 12'h5a1
`define OFR_IDX_IRQ_MASK 12'h5a2

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define OFR_PORT_LSB 0
`define OFR_PORT_MSB 9
`define OFR_RST_DROP_EN 10'h000
`define OFR_RST_OVF_EVT 10'h000
`define OFR_RST_IRQ_STAT 10'h000
`define OFR_RST_IRQ_MASK 10'h000
`define OFR_RST_RDATA 32'h0000_0000

`endif

// [ofr_pkg.sv]
// types shared by the rx fifo drop / overflow register bank
// assumes ofr_map.svh is on the include path
`include "ofr_map.svh"

package ofr_pkg;

    typedef logic [`OFR_PORTS-1:0] ofr_port_vec_t;

    // ----------------------------------------------------------------
    // register port request, one cycle per access
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [`OFR_ADDR_W-1:0] addr;
        logic [`OFR_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ofr_bus_req_t;

    // ----------------------------------------------------------------
    // complete state of the bank
    // ----------------------------------------------------------------
    typedef struct packed {
        ofr_port_vec_t drop_en;
        ofr_port_vec_t ovf_evt;
        ofr_port_vec_t irq_stat;
        ofr_port_vec_t irq_mask;
        ofr_port_vec_t drop;
        logic irq;
        logic [`OFR_DATA_W-1:0] rdata;
    } ofr_state_t;

endpackage

// [ofr_regs.sv]
// rx fifo drop-enable and overflow-event register bank, ten ports
// assumes one clock, synchronous inputs, a master that never waits and never
// issues read and write together; the filter logic flags qualifying frames
`timescale 1ns/1ns

`include "ofr_map.svh"

// Function
// [RULE1] each port has a read/write drop-enable bit at its port number; 1 discards
// [RULE2] qualifying errored or filtered frames are discarded only when drop-enable is set
// [RULE3] all drop-enable bits read zero after reset
// [RULE4] overflow event bit goes to one when that port's fifo is full
// [RULE5] overflow flag of each port sits at the bit equal to its number, up to 9
// [RULE6] reading the overflow register returns the flags and then clears them
// [RULE7] overflow register bits 31:10 are read-only and read zero
// [RULE8] ports 8 and 9 have drop-enable bits 8 and 9, same encoding
// [RULE9] ports 0 to 3 overflow flags at bits 0 to 3, clear on read, reset zero
// [RULE10] an overflow in the same cycle as the clearing read stays set
module ofr_regs (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire ofr_pkg::ofr_bus_req_t BUS_REQ,
    input wire ofr_pkg::ofr_port_vec_t RX_FIFO_FULL,
    input wire ofr_pkg::ofr_port_vec_t RX_FRAME_FLAGGED,
    output logic [`OFR_DATA_W-1:0] RDATA,
    output ofr_pkg::ofr_port_vec_t RX_FRAME_DROP,
    output logic IRQ
);
    import ofr_pkg::*;

    ofr_state_t state_reg;
    ofr_state_t state_next;
    logic [`OFR_ADDR_W-1:0] idx_drop_en;
    logic [`OFR_ADDR_W-1:0] idx_ovf_evt;
    logic [`OFR_ADDR_W-1:0] idx_irq_stat;
    logic [`OFR_ADDR_W-1:0] idx_irq_mask;
    logic [`OFR_ADDR_W-1:0] word_idx;
    logic aligned;
    ofr_port_vec_t wr_bits;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // misaligned byte addresses decode to nothing rather than aliasing a word
    assign idx_drop_en = {4'h0, `OFR_IDX_DROP_EN};
    assign idx_ovf_evt = {4'h0, `OFR_IDX_OVF_EVT};
    assign idx_irq_stat = {4'h0, `OFR_IDX_IRQ_STAT};
    assign idx_irq_mask = {4'h0, `OFR_IDX_IRQ_MASK};
    assign word_idx = {2'h0, BUS_REQ.addr[`OFR_ADDR_W-1:2]};
    assign aligned = (BUS_REQ.addr[1:0] == 2'h0);
    assign wr_bits = BUS_REQ.wdata[`OFR_PORT_MSB:`OFR_PORT_LSB];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.rdata = `OFR_RST_RDATA;
        if (BUS_REQ.wr && aligned && word_idx == idx_drop_en)
        begin
            state_next.drop_en = wr_bits; // [RULE1] [RULE8]
        end
        if (BUS_REQ.wr && aligned && word_idx == idx_irq_mask)
        begin
            state_next.irq_mask = wr_bits;
        end
        if (BUS_REQ.wr && aligned && word_idx == idx_irq_stat)
        begin
            state_next.irq_stat = state_reg.irq_stat & ~wr_bits;
        end
        if (BUS_REQ.rd && aligned)
        begin
            // upper bits stay zero: only the ten port bits are ever placed
            case (word_idx)
                idx_drop_en:
                begin
                    state_next.rdata[`OFR_PORT_MSB:`OFR_PORT_LSB] = state_reg.drop_en;
                end
                idx_ovf_evt:
                begin
                    state_next.rdata[`OFR_PORT_MSB:`OFR_PORT_LSB] = state_reg.ovf_evt; // [RULE5] [RULE7] [RULE9]
                    state_next.ovf_evt = `OFR_RST_OVF_EVT; // [RULE6]
                end
                idx_irq_stat:
                begin
                    state_next.rdata[`OFR_PORT_MSB:`OFR_PORT_LSB] = state_reg.irq_stat;
                end
                idx_irq_mask:
                begin
                    state_next.rdata[`OFR_PORT_MSB:`OFR_PORT_LSB] = state_reg.irq_mask;
                end
                default:
                begin
                    state_next.rdata = `OFR_RST_RDATA;
                end
            endcase
        end
        // set after clear so a full in the read cycle is not lost
        state_next.ovf_evt = state_next.ovf_evt | RX_FIFO_FULL; // [RULE4] [RULE10]
        state_next.irq_stat = state_next.irq_stat | RX_FIFO_FULL;
        // uses the enable already in force this cycle; a write takes effect next frame cycle
        state_next.drop = RX_FRAME_FLAGGED & state_reg.drop_en; // [RULE2]
        state_next.irq = |(state_next.irq_stat & state_next.irq_mask);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            state_reg.drop_en <= `OFR_RST_DROP_EN; // [RULE3]
            state_reg.ovf_evt <= `OFR_RST_OVF_EVT; // [RULE9]
            state_reg.irq_stat <= `OFR_RST_IRQ_STAT;
            state_reg.irq_mask <= `OFR_RST_IRQ_MASK;
            state_reg.drop <= '0;
            state_reg.irq <= 1'b0;
            state_reg.rdata <= `OFR_RST_RDATA;
        end
        else if (CE)
        begin
            state_reg <= state_next;
        end
    end

    assign RDATA = state_reg.rdata;
    assign RX_FRAME_DROP = state_reg.drop;
    assign IRQ = state_reg.irq;
endmodule

// [ofr_chk_assertions.sv]
// port checker of the drop / overflow register bank
// assumes a bind from the bench onto ofr_regs
`timescale 1ns/1ns
`include "ofr_map.svh"
module ofr_chk (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire ofr_pkg::ofr_bus_req_t BUS_REQ,
    input wire ofr_pkg::ofr_port_vec_t RX_FIFO_FULL,
    input wire ofr_pkg::ofr_port_vec_t RX_FRAME_FLAGGED,
    input wire logic [`OFR_DATA_W-1:0] RDATA,
    input wire ofr_pkg::ofr_port_vec_t RX_FRAME_DROP,
    input wire logic IRQ
);
    import ofr_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic ovf_rd;
    assign ovf_rd = CE && BUS_REQ.rd && BUS_REQ.addr == 16'h1680;
    a_rst_quiet: assert property (disable iff (1'b0) !RST_N |=> RDATA == 0 && !IRQ)
        else $error("busy after reset");
    a_drop_rst: assert property (disable iff (1'b0) !RST_N ##1 CE |=> RX_FRAME_DROP == 0)
        else $error("drop after reset");
    a_rdata_idle: assert property (CE && !BUS_REQ.rd |=> RDATA == 0)
        else $error("rdata not idle");
    a_high_zero: assert property (RDATA[31:10] == 0)
        else $error("upper bits set");
    a_flag_seen: assert property (CE && RX_FIFO_FULL != 0 ##1 ovf_rd
        |=> (RDATA[9:0] & $past(RX_FIFO_FULL, 2)) == $past(RX_FIFO_FULL, 2)) else $error("flag lost");
    a_read_clears: assert property (ovf_rd && RX_FIFO_FULL == 0 ##1 ovf_rd |=> RDATA[9:0] == 0)
        else $error("flag not cleared");
    a_drop_gate: assert property (CE && RX_FRAME_FLAGGED == 0 |=> RX_FRAME_DROP == 0)
        else $error("unflagged drop");
    a_drop_follow: assert property (CE && BUS_REQ.wr && BUS_REQ.addr == 16'h167c ##1 CE && !BUS_REQ.wr
        |=> RX_FRAME_DROP == ($past(RX_FRAME_FLAGGED) & $past(BUS_REQ.wdata[9:0], 2))) else $error("drop wrong");
    c_ovf: cover property (ovf_rd ##1 RDATA != 0);
    c_drop: cover property (RX_FRAME_DROP != 0);
    c_irq: cover property (IRQ);
endmodule

// [tb.sv]
// self-checking bench of the drop / overflow register bank
// assumes ofr_pkg compiled first; CE driven by the bench, high except in the freeze scenario
`timescale 1ns/1ns
`include "ofr_map.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb;
    import ofr_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    logic ce = 1;
    ofr_bus_req_t req = '0;
    ofr_port_vec_t full = '0;
    ofr_port_vec_t flg = '0;
    logic [31:0] rdata;
    ofr_port_vec_t drop;
    logic irq;
    int n_errors = 0;
    int comparisons = 0;
    ofr_regs uut (.CLK(clk), .RST_N(rst_n), .CE(ce), .BUS_REQ(req), .RX_FIFO_FULL(full),
        .RX_FRAME_FLAGGED(flg), .RDATA(rdata), .RX_FRAME_DROP(drop), .IRQ(irq));
    initial forever #2 clk = ~clk;
    // the request is dropped at the taking edge, so calls may follow back to back
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        #1;
        `CHK("rdata", e, rdata)
    endtask
    task automatic cyc();
        @(posedge clk);
        #1;
    endtask
    task automatic t_drop();
        wr(16'h167c, 32'hffff_ff5a);
        rd(16'h167c, 32'h0000_035a);
        flg <= 10'h3ff;
        cyc();
        `CHK("drop", 10'h35a, drop)
        wr(16'h167c, 32'h0);
        cyc();
        `CHK("drop", 10'h000, drop)
        flg <= '0;
    endtask
    task automatic t_ovf();
        for (int p = 0; p < 10; p++)
        begin
            full <= 10'h1 << p;
            cyc();
            full <= '0;
            rd(16'h1680, 32'h1 << p);
            rd(16'h1680, 32'h0);
        end
    endtask
    task automatic t_hold();
        wr(16'h1680, 32'hffff_ffff);
        rd(16'h1680, 32'h0);
        rd(16'h1690, 32'h0);
        rd(16'h1681, 32'h0);
        full <= 10'h201;
        rd(16'h1680, 32'h0);
        full <= '0;
        rd(16'h1680, 32'h0000_0201);
    endtask
    task automatic t_irq();
        `CHK("irq", 1'b0, irq)
        wr(16'h1688, 32'h4);
        cyc();
        `CHK("irq", 1'b1, irq)
        rd(16'h1688, 32'h4);
        wr(16'h1684, 32'h4);
        cyc();
        `CHK("irq", 1'b0, irq)
        rd(16'h1684, 32'h3fb);
    endtask
    // freeze: neither a write nor a full event may land while CE is low
    task automatic t_ce();
        ce <= 1'b0;
        full <= 10'h010;
        wr(16'h167c, 32'h3ff);
        ce <= 1'b1;
        full <= '0;
        rd(16'h167c, 32'h0);
        rd(16'h1680, 32'h0);
    endtask
    // second reset in mid-run must bring the drop-enable, overflow and irq status registers and the irq back to zero
    task automatic t_rst();
        wr(16'h167c, 32'h3ff);
        wr(16'h1688, 32'h3ff);
        full <= 10'h3ff;
        cyc();
        full <= '0;
        rst_n <= 1'b0;
        cyc();
        cyc();
        rst_n <= 1'b1;
        cyc();
        `CHK("irq", 1'b0, irq)
        rd(16'h167c, 32'h0);
        rd(16'h1680, 32'h0);
        rd(16'h1684, 32'h0);
    endtask
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        cyc();
        rd(16'h167c, 32'h0);
        rd(16'h1680, 32'h0);
        t_drop();
        t_ovf();
        t_hold();
        t_irq();
        t_ce();
        t_rst();
        end_of_test();
    end
    initial
    begin
        #4000;
        n_errors++;
        end_of_test();
    end
endmodule
bind ofr_regs ofr_chk u_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE), .BUS_REQ(BUS_REQ), .RX_FIFO_FULL(RX_FIFO_FULL),
    .RX_FRAME_FLAGGED(RX_FRAME_FLAGGED), .RDATA(RDATA), .RX_FRAME_DROP(RX_FRAME_DROP), .IRQ(IRQ));
